// ---- rtl/mes_logger.sv ----
// memory ecc datapath with syndrome log, ecc control and error counters.
// assumes all request inputs and error_log_valid are on mclk; the error
// address log outside sets error_log_valid on the edge after error_capture.
//
// Notes on behaviour
// - syndrome log holds unchanged by reads while the error address log valid flag is set.
// - syndrome log clears on reset and on any processor write to the syndrome log.
// - high valid bit sets whenever the high check field updates.
// - high check field tracks last high-bank check bits until an error is logged.
// - bit 23 records single (1) or double or multi (0) for a high-bank error.
// - bits 22:16 record the high-bank syndrome on a high-bank error.
// - low valid bit sets whenever the low check field updates.
// - low check field tracks last low-bank check bits until an error is logged.
// - bits 6:0 record the low-bank syndrome on a low-bank error.
// - bit 7 records single (1) or double or multi (0) for a low-bank error.
// - ecc control is read/write and clears to zero on reset.
// - control bit 15 substitutes the diagnostic check value on reads.
// - control bit 14 substitutes the diagnostic check value on writes.
// - control bit 13 inverts the data bit named by the syndrome.
// - correction enable changes only returned data, never logging or errors.
// - control bit 10 selects 8 or 32 megabyte bank stride.
// - seven check bits are made on writes and verified on reads.
// - first single, double or multi error loads address, check and syndrome logs.
// - each check bit is xor of listed data bits, c1 and c2 odd.
// - check field packs c16, c8, c4, c1, c2, c0, cx by weight.
// - syndrome zero is clean, listed and one-hot codes single, others double or multi.
// - hard error lines pulse for double-bit syndromes only.
// - while the valid flag is set, later errors are not logged.
//
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module mes_logger
	import mes_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// memory write path
	input wire logic wr_valid,
	input wire logic [31:0] wr_data,
	output logic wr_out_valid,
	output logic [31:0] wr_out_data,
	output logic [6:0] wr_out_check,
	// memory read path
	input wire logic rd_valid,
	input wire logic [31:0] rd_data,
	input wire logic [6:0] rd_check,
	input wire logic rd_high_bank,
	input wire logic rd_from_processor,
	output logic rd_out_valid,
	output logic [31:0] rd_out_data,
	output logic rd_single_error,
	output logic rd_double_error,
	output logic rd_multi_error,
	output logic processor_read_hard_error_n,
	output logic option_bus_hard_error_n,
	// error address log handshake
	input wire logic error_log_valid,
	output logic error_capture,
	// array decode
	output logic large_bank_stride
);

	// control register fields, reserved bits are not stored and read as zero
	logic read_check_override;
	logic write_check_override;
	logic correct_enable;
	logic [6:0] diag_check;

	// syndrome log fields
	logic high_log_valid;
	logic [6:0] high_bank_check_bits;
	logic high_single_flag;
	logic [6:0] high_bank_syndrome;
	logic low_log_valid;
	logic [6:0] low_bank_check_bits;
	logic low_single_flag;
	logic [6:0] low_bank_syndrome;

	logic [15:0] single_count;
	logic [15:0] double_count;

	// apb decode
	logic apb_setup;
	logic apb_write;
	logic sel_log;
	logic sel_ctrl;
	logic sel_count;

	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pready & pwrite;
	assign sel_log = (paddr == MES_SYN_LOG_ADDR);
	assign sel_ctrl = (paddr == MES_ECC_CTRL_ADDR);
	assign sel_count = (paddr == MES_ERR_COUNT_ADDR);

	// check-bit generator shared by both paths
	function automatic logic [6:0] mes_gen_check(input logic [31:0] d);
		logic [6:0] even;
		even = {^(d & MES_MASK_C16), ^(d & MES_MASK_C8), ^(d & MES_MASK_C4),
			^(d & MES_MASK_C1), ^(d & MES_MASK_C2), ^(d & MES_MASK_C0),
			^(d & MES_MASK_CX)};
		mes_gen_check = even ^ MES_ODD_PARITY;
	endfunction

	// read path decode
	logic [6:0] used_check;
	logic [6:0] syndrome;
	logic [31:0] flip_mask;
	logic check_bit_hit;
	logic syn_single;
	logic syn_multi;
	logic syn_double;
	logic syn_error;
	logic log_frozen;

	assign used_check = read_check_override ? diag_check : rd_check;
	assign syndrome = used_check ^ mes_gen_check(rd_data);

	genvar gi;
	generate
		for (gi = 0; gi < 32; gi++) begin : g_flip
			assign flip_mask[gi] = (syndrome == MES_DATA_SYN[gi]);
		end
	endgenerate

	// a lone check-bit error has a one-hot syndrome
	assign check_bit_hit = (syndrome != MES_ZERO_CHECK) &&
		((syndrome & (syndrome - 7'h01)) == MES_ZERO_CHECK);
	assign syn_single = (|flip_mask) | check_bit_hit;
	assign syn_multi = mes_is_multi(syndrome);
	assign syn_double = (syndrome != MES_ZERO_CHECK) & ~syn_single & ~syn_multi;
	assign syn_error = rd_valid & (syndrome != MES_ZERO_CHECK);

	// the external valid flag lags our capture by one edge; the capture
	// pulse covers that gap so a second error cannot slip in behind it
	assign log_frozen = error_log_valid | error_capture;

	// control register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			read_check_override <= MES_ECC_CTRL_RESET[MES_CTRL_RD_OVR_BIT];
			write_check_override <= MES_ECC_CTRL_RESET[MES_CTRL_WR_OVR_BIT];
			correct_enable <= MES_ECC_CTRL_RESET[MES_CTRL_CORRECT_BIT];
			large_bank_stride <= MES_ECC_CTRL_RESET[MES_CTRL_STRIDE_BIT];
			diag_check <= MES_ECC_CTRL_RESET[MES_CTRL_CHECK_LSB +: 7];
		end else if (apb_write && sel_ctrl) begin
			read_check_override <= pwdata[MES_CTRL_RD_OVR_BIT];
			write_check_override <= pwdata[MES_CTRL_WR_OVR_BIT];
			correct_enable <= pwdata[MES_CTRL_CORRECT_BIT];
			large_bank_stride <= pwdata[MES_CTRL_STRIDE_BIT];
			diag_check <= pwdata[MES_CTRL_CHECK_LSB +: 7];
		end
	end

	// write path: one register stage
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wr_out_valid <= 1'b0;
			wr_out_data <= 32'h0000_0000;
			wr_out_check <= MES_ZERO_CHECK;
		end else begin
			wr_out_valid <= wr_valid;
			if (wr_valid) begin
				wr_out_data <= wr_data;
				wr_out_check <= write_check_override ? diag_check
					: mes_gen_check(wr_data);
			end
		end
	end

	// read path: correction touches only the data word
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_out_valid <= 1'b0;
			rd_out_data <= 32'h0000_0000;
		end else begin
			rd_out_valid <= rd_valid;
			if (rd_valid) begin
				rd_out_data <= correct_enable ? (rd_data ^ flip_mask)
					: rd_data;
			end
		end
	end

	// error flags and hard error lines, independent of correct_enable
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rd_single_error <= 1'b0;
			rd_double_error <= 1'b0;
			rd_multi_error <= 1'b0;
			processor_read_hard_error_n <= 1'b1;
			option_bus_hard_error_n <= 1'b1;
		end else begin
			rd_single_error <= rd_valid & syn_single;
			rd_double_error <= rd_valid & syn_double;
			rd_multi_error <= rd_valid & syn_multi;
			// multi-bit codes deliberately raise no hard error
			processor_read_hard_error_n <= ~(rd_valid & syn_double &
				rd_from_processor);
			option_bus_hard_error_n <= ~(rd_valid & syn_double &
				~rd_from_processor);
		end
	end

	// capture strobe toward the error address log
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			error_capture <= 1'b0;
		end else begin
			error_capture <= syn_error & ~log_frozen;
		end
	end

	// syndrome log, high half
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			high_log_valid <= MES_SYN_LOG_RESET[MES_HI_VALID_BIT];
			high_bank_check_bits <= MES_SYN_LOG_RESET[MES_HI_CHECK_LSB +: 7];
			high_single_flag <= MES_SYN_LOG_RESET[MES_HI_SINGLE_BIT];
			high_bank_syndrome <= MES_SYN_LOG_RESET[MES_HI_SYN_LSB +: 7];
		end else if (apb_write && sel_log) begin
			// write clears regardless of data and beats a capture
			high_log_valid <= 1'b0;
			high_bank_check_bits <= MES_ZERO_CHECK;
			high_single_flag <= 1'b0;
			high_bank_syndrome <= MES_ZERO_CHECK;
		end else if (rd_valid && rd_high_bank && !log_frozen) begin
			high_bank_check_bits <= used_check;
			high_log_valid <= 1'b1;
			if (syn_error) begin
				high_bank_syndrome <= syndrome;
				high_single_flag <= syn_single;
			end
		end
	end

	// syndrome log, low half
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			low_log_valid <= MES_SYN_LOG_RESET[MES_LO_VALID_BIT];
			low_bank_check_bits <= MES_SYN_LOG_RESET[MES_LO_CHECK_LSB +: 7];
			low_single_flag <= MES_SYN_LOG_RESET[MES_LO_SINGLE_BIT];
			low_bank_syndrome <= MES_SYN_LOG_RESET[MES_LO_SYN_LSB +: 7];
		end else if (apb_write && sel_log) begin
			low_log_valid <= 1'b0;
			low_bank_check_bits <= MES_ZERO_CHECK;
			low_single_flag <= 1'b0;
			low_bank_syndrome <= MES_ZERO_CHECK;
		end else if (rd_valid && !rd_high_bank && !log_frozen) begin
			low_bank_check_bits <= used_check;
			low_log_valid <= 1'b1;
			if (syn_error) begin
				low_bank_syndrome <= syndrome;
				low_single_flag <= syn_single;
			end
		end
	end

	// saturating error counters; a write clears, a same-cycle event is kept
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			single_count <= MES_CNT_RESET;
			double_count <= MES_CNT_RESET;
		end else begin
			if (apb_write && sel_count) begin
				single_count <= {15'h0000, rd_valid & syn_single};
				double_count <= {15'h0000, rd_valid & syn_double};
			end else begin
				if (rd_valid && syn_single && single_count != 16'hffff) begin
					single_count <= single_count + 16'h0001;
				end
				if (rd_valid && syn_double && double_count != 16'hffff) begin
					double_count <= double_count + 16'h0001;
				end
			end
		end
	end

	// apb answer: data and ready are registered in the setup cycle, so
	// every access finishes in its first access cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= apb_setup;
			if (apb_setup) begin
				pslverr <= ~(sel_log | sel_ctrl | sel_count);
				prdata <= 32'h0000_0000;
				if (!pwrite) begin
					if (sel_log) begin
						prdata <= {high_log_valid, high_bank_check_bits, high_single_flag,
							high_bank_syndrome, low_log_valid, low_bank_check_bits,
							low_single_flag, low_bank_syndrome};
					end else if (sel_ctrl) begin
						prdata <= {16'h0000, read_check_override, write_check_override,
							correct_enable, 2'b00, large_bank_stride, 3'b000,
							diag_check};
					end else if (sel_count) begin
						prdata <= {double_count, single_count};
					end
				end
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

endmodule // mes_logger

`default_nettype wire

// ---- rtl/mes_pkg.sv ----
// constants for the memory ecc syndrome logger: register map, field layout,
// check-bit equations and syndrome codes.
// assumes a 32-bit apb register port and 32-bit data words with 7 check bits.
package mes_pkg;

	// register byte addresses
	localparam logic [31:0] MES_SYN_LOG_ADDR = 32'hbfa8_0000;
	localparam logic [31:0] MES_ECC_CTRL_ADDR = 32'hbfac_0000;
	localparam logic [31:0] MES_ERR_COUNT_ADDR = 32'hbfb0_0000;

	// syndrome log fields
	localparam int MES_HI_VALID_BIT = 31;
	localparam int MES_HI_CHECK_LSB = 24;
	localparam int MES_HI_SINGLE_BIT = 23;
	localparam int MES_HI_SYN_LSB = 16;
	localparam int MES_LO_VALID_BIT = 15;
	localparam int MES_LO_CHECK_LSB = 8;
	localparam int MES_LO_SINGLE_BIT = 7;
	localparam int MES_LO_SYN_LSB = 0;
	localparam logic [31:0] MES_SYN_LOG_RESET = 32'h0000_0000;

	// control fields
	localparam int MES_CTRL_RD_OVR_BIT = 15;
	localparam int MES_CTRL_WR_OVR_BIT = 14;
	localparam int MES_CTRL_CORRECT_BIT = 13;
	localparam int MES_CTRL_STRIDE_BIT = 10;
	localparam int MES_CTRL_CHECK_LSB = 0;
	localparam logic [31:0] MES_ECC_CTRL_RESET = 32'h0000_0000;

	// error count fields
	localparam int MES_CNT_SINGLE_LSB = 0;
	localparam int MES_CNT_DOUBLE_LSB = 16;
	localparam logic [15:0] MES_CNT_RESET = 16'h0000;

	localparam logic [6:0] MES_ZERO_CHECK = 7'h00;

	// data bits feeding each check bit, packed order c16 c8 c4 c1 c2 c0 cx
	localparam logic [31:0] MES_MASK_C16 = 32'hff00_00ff;
	localparam logic [31:0] MES_MASK_C8 = 32'hff00_df00;
	localparam logic [31:0] MES_MASK_C4 = 32'hc0fc_c0fc;
	localparam logic [31:0] MES_MASK_C1 = 32'ha699_a699;
	localparam logic [31:0] MES_MASK_C2 = 32'h38e3_38e3;
	localparam logic [31:0] MES_MASK_C0 = 32'h1557_1557;
	localparam logic [31:0] MES_MASK_CX = 32'hb42e_4bd1;
	// c1 and c2 are odd parity, the rest even
	localparam logic [6:0] MES_ODD_PARITY = 7'h0c;

	// syndrome that names each data bit, index is the data bit
	localparam logic [6:0] MES_DATA_SYN [0:31] = '{
		7'h4f, 7'h4a, 7'h52, 7'h54, 7'h57, 7'h58, 7'h5b, 7'h5d,
		7'h23, 7'h25, 7'h26, 7'h29, 7'h2a, 7'h2c, 7'h31, 7'h34,
		7'h0e, 7'h0b, 7'h13, 7'h15, 7'h16, 7'h19, 7'h1a, 7'h1c,
		7'h62, 7'h64, 7'h67, 7'h68, 7'h6b, 7'h6d, 7'h70, 7'h75
	};

	// multi-bit syndromes: detected but never reported as hard errors
	function automatic logic mes_is_multi(input logic [6:0] syn);
		unique case (syn)
			7'h07, 7'h0d, 7'h1f, 7'h2f, 7'h32, 7'h37, 7'h38, 7'h3b, 7'h3d,
			7'h3e, 7'h43, 7'h45, 7'h46, 7'h49, 7'h4c, 7'h51, 7'h5e, 7'h61,
			7'h6e, 7'h73, 7'h76, 7'h79, 7'h7a, 7'h7c, 7'h7f: mes_is_multi = 1'b1;
			default: mes_is_multi = 1'b0;
		endcase
	endfunction

endpackage

// ---- testbench/mes_logger_checker.sv ----
// port assertions for mes_logger, bound into every instance.
// assumes the control word changes only through apb writes.
`timescale 1ns/1ps
`default_nettype none
module mes_logger_checker
	import mes_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic wr_valid,
	input wire logic [6:0] wr_out_check,
	input wire logic rd_valid,
	input wire logic rd_from_processor,
	input wire logic rd_single_error,
	input wire logic rd_double_error,
	input wire logic rd_multi_error,
	input wire logic processor_read_hard_error_n,
	input wire logic option_bus_hard_error_n,
	input wire logic error_log_valid,
	input wire logic error_capture,
	input wire logic large_bank_stride
);
	logic [31:0] ctl;
	logic [6:0] diag;
	logic any_err;
	// shadow of the control word; reserved bits read zero
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			ctl <= 32'h0000_0000;
		end else if (psel && penable && pready && pwrite && paddr == MES_ECC_CTRL_ADDR) begin
			ctl <= pwdata & 32'h0000_e47f;
		end
	end
	assign diag = ctl[6:0];
	assign any_err = rd_single_error || rd_double_error || rd_multi_error;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_ctl;
		psel && penable && pready && paddr == MES_ECC_CTRL_ADDR;
	endsequence
	property p_stride; s_ctl ##0 pwrite |=> large_bank_stride == $past(pwdata[10]); endproperty
	a_stride: assert property (p_stride) else $error("stride bit wrong");
	property p_ctl_rd; s_ctl ##0 !pwrite |-> prdata == ctl; endproperty
	a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
	property p_wr_diag; wr_valid && ctl[14] |=> wr_out_check == $past(diag); endproperty
	a_wr_diag: assert property (p_wr_diag) else $error("diag write check wrong");
	property p_capture; any_err |-> error_capture || $past(error_log_valid) || $past(error_capture);
	endproperty
	a_capture: assert property (p_capture) else $error("error not captured");
	property p_frozen; error_capture |-> $past(rd_valid) && !$past(error_log_valid) && any_err;
	endproperty
	a_frozen: assert property (p_frozen) else $error("capture while frozen");
	property p_one_kind; $onehot0({rd_single_error, rd_double_error, rd_multi_error}); endproperty
	a_one_kind: assert property (p_one_kind) else $error("two error kinds at once");
	property p_hard_dbl; rd_double_error |-> processor_read_hard_error_n == !$past(rd_from_processor)
		&& option_bus_hard_error_n == $past(rd_from_processor); endproperty
	a_hard_dbl: assert property (p_hard_dbl) else $error("hard error line wrong");
	property p_hard_only; !processor_read_hard_error_n || !option_bus_hard_error_n |->
		rd_double_error; endproperty
	a_hard_only: assert property (p_hard_only) else $error("hard error without double");
endmodule // mes_logger_checker
bind mes_logger mes_logger_checker u_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .wr_valid(wr_valid), .wr_out_check(wr_out_check), .rd_valid(rd_valid),
	.rd_from_processor(rd_from_processor), .rd_single_error(rd_single_error),
	.rd_double_error(rd_double_error), .rd_multi_error(rd_multi_error),
	.processor_read_hard_error_n(processor_read_hard_error_n),
	.option_bus_hard_error_n(option_bus_hard_error_n), .error_log_valid(error_log_valid),
	.error_capture(error_capture), .large_bank_stride(large_bank_stride));
`default_nettype wire

// ---- testbench/mes_mem_model.sv ----
// memory array card and error address log flag facing the logger.
// assumes the bench holds mem_addr steady through each access.
`timescale 1ns/1ps
`default_nettype none
module mes_mem_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] mem_addr,
	input wire logic rd_req,
	input wire logic [31:0] rd_flip,
	input wire logic wr_out_valid,
	input wire logic [31:0] wr_out_data,
	input wire logic [6:0] wr_out_check,
	input wire logic error_capture,
	input wire logic ea_clear,
	output logic rd_valid,
	output logic [31:0] rd_data,
	output logic [6:0] rd_check,
	output logic rd_high_bank,
	output logic error_log_valid
);
	logic [31:0] words [0:15];
	logic [6:0] checks [0:15];
	always_ff @(posedge mclk) begin
		if (wr_out_valid) begin
			words[mem_addr] <= wr_out_data;
			checks[mem_addr] <= wr_out_check;
		end
	end
	// idle lines show the inverse so stale data cannot pass
	assign rd_valid = rd_req;
	assign rd_data = rd_req ? words[mem_addr] ^ rd_flip : ~words[mem_addr];
	assign rd_check = rd_req ? checks[mem_addr] : ~checks[mem_addr];
	assign rd_high_bank = mem_addr[0];
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			error_log_valid <= 1'b0;
		end else if (ea_clear) begin
			error_log_valid <= 1'b0;
		end else if (error_capture) begin
			error_log_valid <= 1'b1;
		end
	end
endmodule // mes_mem_model
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for mes_logger with a memory model on the far side.
// assumes zero-wait apb and one-cycle datapath latency as handed over.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_top
	import mes_pkg::*;
;
	logic mclk, rst_n, psel, penable, pwrite, wr_valid, rd_req, rd_from_processor, ea_clear;
	logic [31:0] paddr, pwdata, prdata, wr_data, rd_flip, wr_out_data, rd_data, rd_out_data, q;
	logic [6:0] wr_out_check, rd_check;
	logic [3:0] mem_addr;
	logic pready, pslverr, slv, wr_out_valid, rd_valid, rd_high_bank, rd_out_valid;
	logic rd_single_error, rd_double_error, rd_multi_error, error_log_valid, error_capture;
	logic processor_read_hard_error_n, option_bus_hard_error_n, large_bank_stride;
	int err_total, num_checks;
	mes_logger dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.wr_valid(wr_valid), .wr_data(wr_data), .wr_out_valid(wr_out_valid),
		.wr_out_data(wr_out_data), .wr_out_check(wr_out_check), .rd_valid(rd_valid),
		.rd_data(rd_data), .rd_check(rd_check), .rd_high_bank(rd_high_bank),
		.rd_from_processor(rd_from_processor), .rd_out_valid(rd_out_valid),
		.rd_out_data(rd_out_data), .rd_single_error(rd_single_error),
		.rd_double_error(rd_double_error), .rd_multi_error(rd_multi_error),
		.processor_read_hard_error_n(processor_read_hard_error_n),
		.option_bus_hard_error_n(option_bus_hard_error_n), .error_log_valid(error_log_valid),
		.error_capture(error_capture), .large_bank_stride(large_bank_stride));
	mes_mem_model u_mem (.mclk(mclk), .rst_n(rst_n), .mem_addr(mem_addr), .rd_req(rd_req),
		.rd_flip(rd_flip), .wr_out_valid(wr_out_valid), .wr_out_data(wr_out_data),
		.wr_out_check(wr_out_check), .error_capture(error_capture), .ea_clear(ea_clear),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_check(rd_check),
		.rd_high_bank(rd_high_bank), .error_log_valid(error_log_valid));
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	task automatic tally_and_finish();
		if (err_total == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] wd);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		// answer is taken at the very rising edge that sees pready high
		@(posedge mclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 20) begin
				err_total++;
				tally_and_finish();
			end
			@(posedge mclk);
		end
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic mem_wr(input logic [3:0] a, input logic [31:0] wd, input logic [6:0] ec);
		@(posedge mclk);
		wr_valid <= 1'b1;
		wr_data <= wd;
		mem_addr <= a;
		@(posedge mclk);
		wr_valid <= 1'b0;
		@(negedge mclk);
		`CHK("write check", ec, wr_out_check)
		`CHK("write valid", 1'b1, wr_out_valid)
		`CHK("write data", wd, wr_out_data)
	endtask
	task automatic mem_rd(input logic [3:0] a, input logic [31:0] f, input logic p);
		@(posedge mclk);
		rd_req <= 1'b1;
		mem_addr <= a;
		rd_flip <= f;
		rd_from_processor <= p;
		@(posedge mclk);
		rd_req <= 1'b0;
		@(negedge mclk);
		`CHK("read valid", 1'b1, rd_out_valid)
	endtask
	task automatic clear_logs();
		apb(1'b1, MES_SYN_LOG_ADDR, 32'hffff_ffff);
		@(posedge mclk);
		ea_clear <= 1'b1;
		@(posedge mclk);
		ea_clear <= 1'b0;
	endtask
	initial begin
		{psel, penable, pwrite, wr_valid, rd_req, rd_from_processor, ea_clear} = 7'h00;
		{paddr, pwdata, wr_data, rd_flip} = 128'h0;
		mem_addr = 4'h0;
		err_total = 0;
		num_checks = 0;
		rst_n = 1'b0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		apb(1'b0, MES_SYN_LOG_ADDR, 32'h0);
		`CHK("log reset", 32'h0, q)
		apb(1'b0, MES_ECC_CTRL_ADDR, 32'h0);
		`CHK("ctrl reset", 32'h0, q)
		apb(1'b1, MES_ECC_CTRL_ADDR, 32'h0000_e47f);
		apb(1'b0, MES_ECC_CTRL_ADDR, 32'h0);
		`CHK("ctrl rw", 32'h0000_e47f, q)
		`CHK("stride", 1'b1, large_bank_stride)
		apb(1'b0, 32'hbfa4_0000, 32'h0);
		`CHK("unmapped", 1'b1, slv)
		apb(1'b1, MES_ECC_CTRL_ADDR, 32'h0000_4055);
		mem_wr(4'h3, 32'h0, 7'h55);
		apb(1'b1, MES_ECC_CTRL_ADDR, 32'h0000_2000);
		// zero word: only the two odd bits set, weights 8 and 4
		mem_wr(4'h0, 32'h0, 7'h0c);
		// data bits 0 and 4 together move the check by 7'h14
		mem_wr(4'h1, 32'h11, 7'h18);
		mem_rd(4'h0, 32'h0, 1'b1);
		mem_rd(4'h1, 32'h0, 1'b1);
		apb(1'b0, MES_SYN_LOG_ADDR, 32'h0);
		`CHK("clean log", {1'b1, 7'h18, 8'h00, 1'b1, 7'h0c, 8'h00}, q)
		mem_rd(4'h0, 32'h1, 1'b1);
		`CHK("corrected", 32'h0, rd_out_data)
		`CHK("single", 1'b1, rd_single_error)
		`CHK("capture", 1'b1, error_capture)
		mem_rd(4'h1, 32'h1, 1'b1);
		apb(1'b0, MES_SYN_LOG_ADDR, 32'h0);
		`CHK("frozen log", {1'b1, 7'h18, 8'h00, 1'b1, 7'h0c, 8'hcf}, q)
		clear_logs();
		apb(1'b0, MES_SYN_LOG_ADDR, 32'h0);
		`CHK("log cleared", 32'h0, q)
		apb(1'b1, MES_ECC_CTRL_ADDR, 32'h0);
		mem_rd(4'h1, 32'h11, 1'b1);
		`CHK("raw data", 32'h0, rd_out_data)
		`CHK("proc hard", 1'b0, processor_read_hard_error_n)
		apb(1'b0, MES_SYN_LOG_ADDR, 32'h0);
		`CHK("double log", {1'b1, 7'h18, 8'h14, 16'h0}, q)
		clear_logs();
		apb(1'b1, MES_ECC_CTRL_ADDR, 32'h0000_800b);
		mem_rd(4'h0, 32'h0, 1'b0);
		`CHK("multi", 1'b1, rd_multi_error)
		`CHK("opt hard", 1'b1, option_bus_hard_error_n)
		apb(1'b0, MES_SYN_LOG_ADDR, 32'h0);
		`CHK("multi syn", 8'h07, q[7:0])
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
